// file: core/oag_defs.svh
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
// widths
`define OAG_DATA_W      16
`define OAG_PROG_W      24
`define OAG_FILE_W      13
`define OAG_LIT5_W      5
`define OAG_LIT10_W     10
`define OAG_LIT8_W      8
`define OAG_LIT14_W     14
`define OAG_PAGE_W      8
`define OAG_VIS_LOW_W   15
`define OAG_WSEL_W      4
// near data region size in bytes
`define OAG_NEAR_BYTES  8192
// reset values
`define OAG_EA_RST      16'h0000
`define OAG_PA_RST      24'h000000
`endif

// file: core/oag_ea_unit.sv
`timescale 1ns/1ps
`include "oag_defs.svh"
module oag_ea_unit
	import oag_pkg::*;
#(
	parameter int DW = `OAG_DATA_W
) (
	// mode and operands
	input  wire oag_mode_t       mode,
	input  wire logic [DW-1:0]   ptr,
	input  wire logic [DW-1:0]   ofs,
	input  wire logic [DW-1:0]   lit,
	input  wire logic [DW-1:0]   step,
	input  wire logic            dec,
	// results
	output logic      [DW-1:0]   ea,
	output logic      [DW-1:0]   ptr_new,
	output logic                 ptr_wr,
	output logic                 is_mem
);
	function automatic logic [DW-1:0] wrap_add(input logic [DW-1:0] a,
		input logic [DW-1:0] b);
		wrap_add = a + b;
	endfunction
	logic [DW-1:0] stepped;
	assign stepped = dec ? wrap_add(ptr, (~step) + 1'b1) : wrap_add(ptr, step);
	always_comb begin
		ea      = ptr;
		ptr_new = ptr;
		ptr_wr  = 1'b0;
		is_mem  = 1'b1;
		unique case (mode)
			OAG_M_IND: ea = ptr;
			OAG_M_POST: begin
				ea      = ptr;
				ptr_new = stepped;
				ptr_wr  = 1'b1;
			end
			OAG_M_PRE: begin
				ea      = stepped;
				ptr_new = stepped;
				ptr_wr  = 1'b1;
			end
			OAG_M_INDEX: ea = wrap_add(ptr, ofs);
			OAG_M_LITOFS: ea = wrap_add(ptr, lit);
			default: begin
				ea     = lit;
				is_mem = 1'b0;
			end
		endcase
	end
endmodule // oag_ea_unit

// file: core/oag_pkg.sv
package oag_pkg;
	typedef enum logic [3:0] {
		OAG_M_FILE     = 4'h0,
		OAG_M_REG      = 4'h1,
		OAG_M_IND      = 4'h2,
		OAG_M_POST     = 4'h3,
		OAG_M_PRE      = 4'h4,
		OAG_M_INDEX    = 4'h5,
		OAG_M_LITOFS   = 4'h6,
		OAG_M_LIT5     = 4'h7,
		OAG_M_LIT10    = 4'h8,
		OAG_M_LIT8     = 4'h9,
		OAG_M_LIT16    = 4'ha,
		OAG_M_JUMP     = 4'hb,
		OAG_M_HOLD     = 4'hc,
		OAG_M_TABLE    = 4'hd
	} oag_mode_t;
	typedef enum logic [1:0] {
		OAG_C_GEN   = 2'h0,
		OAG_C_THREE = 2'h1,
		OAG_C_MOVE  = 2'h2,
		OAG_C_OTHER = 2'h3
	} oag_class_t;
	typedef enum logic [1:0] {
		OAG_S_DATA  = 2'h0,
		OAG_S_TABLE = 2'h1,
		OAG_S_REMAP = 2'h2
	} oag_space_t;
endpackage

// file: core/oag_top.sv
`timescale 1ns/1ps
`include "oag_defs.svh"
module oag_top
	import oag_pkg::*;
#(
	parameter int DW = `OAG_DATA_W,
	parameter int PW = `OAG_PROG_W
) (
	// clock and reset
	input  wire logic                REF_CLK,
	input  wire logic                SYS_RST,
	// request from pipeline
	input  wire logic                REQ_VALID,
	input  wire oag_class_t          REQ_CLASS,
	input  wire oag_mode_t           SRC_MODE,
	input  wire oag_mode_t           DST_MODE,
	input  wire logic [DW-1:0]       SRC_PTR,
	input  wire logic [DW-1:0]       DST_PTR,
	input  wire logic [DW-1:0]       OFFSET_SOURCE_REGISTER,
	input  wire logic [`OAG_WSEL_W-1:0] OFFSET_SEL,
	input  wire logic [DW-1:0]       OPCODE_LIT,
	input  wire logic [DW-1:0]       STEP,
	input  wire logic                STEP_DEC,
	input  wire logic                DST_TO_FILE,
	input  wire logic                IS_WRITE,
	input  wire logic                TABLE_ACCESS,
	input  wire logic                TABLE_BYTE_HI,
	// protection and paging
	input  wire logic                BOOT_PROT_EN,
	input  wire logic                SECURE_PROT_EN,
	input  wire logic                EXEC_IN_BOOT,
	input  wire logic                EXEC_IN_SECURE,
	input  wire logic [DW-1:0]       BOOT_SEG_LO,
	input  wire logic [DW-1:0]       BOOT_SEG_HI,
	input  wire logic [DW-1:0]       SEC_SEG_LO,
	input  wire logic [DW-1:0]       SEC_SEG_HI,
	input  wire logic [`OAG_PAGE_W-1:0] TABLE_PAGE_VALUE,
	input  wire logic [`OAG_PAGE_W-1:0] VISIBILITY_PAGE_VALUE,
	input  wire logic                PROGRAM_WINDOW_REMAP,
	// results
	output logic                     RSP_VALID,
	output logic [DW-1:0]            SRC_EA,
	output logic [DW-1:0]            DST_EA,
	output logic                     SRC_IS_MEM,
	output logic                     DST_IS_MEM,
	output logic [DW-1:0]            SRC_PTR_NEW,
	output logic                     SRC_PTR_WR,
	output logic [DW-1:0]            DST_PTR_NEW,
	output logic                     DST_PTR_WR,
	output logic                     DST_TO_ACC,
	output logic [`OAG_WSEL_W-1:0]   OFFSET_SEL_OUT,
	output oag_space_t               SPACE,
	output logic [PW-1:0]            PROG_ADDR,
	output logic                     CONFIG_SPACE,
	output logic                     TABLE_HI_BYTE,
	output logic                     ACCESS_FAULT
);
	initial begin
		if (DW != `OAG_DATA_W || PW != `OAG_PROG_W)
			$error("oag_top supports only 16-bit data, 24-bit program");
	end

	// source mode legalisation per class
	function automatic oag_mode_t legal_src(input oag_class_t c,
		input oag_mode_t m);
		legal_src = m;
		unique case (c)
			OAG_C_THREE:
				if (m == OAG_M_INDEX || m == OAG_M_LITOFS ||
					m == OAG_M_LIT8 || m == OAG_M_LIT16 ||
					m == OAG_M_LIT10 || m == OAG_M_FILE)
					legal_src = OAG_M_REG;
			OAG_C_GEN:
				if (m == OAG_M_INDEX || m == OAG_M_LITOFS ||
					m == OAG_M_LIT8 || m == OAG_M_LIT16)
					legal_src = OAG_M_REG;
			OAG_C_MOVE, OAG_C_OTHER: ;
		endcase
	endfunction

	// literal width by mode
	function automatic logic [DW-1:0] shape_lit(input oag_mode_t m,
		input logic [DW-1:0] l);
		unique case (m)
			OAG_M_FILE:   shape_lit = {3'h0, l[`OAG_FILE_W-1:0]};
			OAG_M_LIT5:   shape_lit = {11'h000, l[`OAG_LIT5_W-1:0]};
			OAG_M_LIT10:  shape_lit = {6'h00, l[`OAG_LIT10_W-1:0]};
			OAG_M_LIT8:   shape_lit = {8'h00, l[`OAG_LIT8_W-1:0]};
			OAG_M_HOLD:   shape_lit = {2'h0, l[`OAG_LIT14_W-1:0]};
			default:      shape_lit = l;
		endcase
	endfunction

	function automatic logic in_seg(input logic [DW-1:0] a,
		input logic [DW-1:0] lo, input logic [DW-1:0] hi);
		in_seg = (a >= lo) && (a <= hi);
	endfunction

	oag_mode_t      src_m;
	oag_mode_t      dst_m;
	logic [DW-1:0]  src_lit;
	logic [DW-1:0]  dst_lit;
	logic [DW-1:0]  s_ea;
	logic [DW-1:0]  d_ea;
	logic [DW-1:0]  s_pn;
	logic [DW-1:0]  d_pn;
	logic           s_pw;
	logic           d_pw;
	logic           s_mem;
	logic           d_mem;
	logic           boot_hit;
	logic           sec_hit;
	logic           fault_next;
	oag_space_t     space_next;
	logic [PW-1:0]  pa_next;

	assign src_m   = legal_src(REQ_CLASS, SRC_MODE);
	assign dst_m   = (REQ_CLASS == OAG_C_MOVE) ? DST_MODE :
		legal_src(REQ_CLASS, DST_MODE);
	assign src_lit = shape_lit(src_m, OPCODE_LIT);
	assign dst_lit = shape_lit(dst_m, OPCODE_LIT);

	oag_ea_unit #(.DW(DW)) u_src (
		.mode    (src_m),
		.ptr     (SRC_PTR),
		.ofs     (OFFSET_SOURCE_REGISTER),
		.lit     (src_lit),
		.step    (STEP),
		.dec     (STEP_DEC),
		.ea      (s_ea),
		.ptr_new (s_pn),
		.ptr_wr  (s_pw),
		.is_mem  (s_mem)
	);
	oag_ea_unit #(.DW(DW)) u_dst (
		.mode    (dst_m),
		.ptr     (DST_PTR),
		.ofs     (OFFSET_SOURCE_REGISTER),
		.lit     (dst_lit),
		.step    (STEP),
		.dec     (STEP_DEC),
		.ea      (d_ea),
		.ptr_new (d_pn),
		.ptr_wr  (d_pw),
		.is_mem  (d_mem)
	);

	logic src_file;
	logic dst_file;
	logic s_mem_eff;
	logic d_mem_eff;
	assign src_file  = (src_m == OAG_M_FILE);
	assign dst_file  = (dst_m == OAG_M_FILE);
	assign s_mem_eff = (s_mem || src_file) && src_m != OAG_M_REG;
	assign d_mem_eff = (d_mem || dst_file) && dst_m != OAG_M_REG;

	assign boot_hit = BOOT_PROT_EN && !EXEC_IN_BOOT &&
		((s_mem_eff && in_seg(s_ea, BOOT_SEG_LO, BOOT_SEG_HI)) ||
		 (d_mem_eff && in_seg(d_ea, BOOT_SEG_LO, BOOT_SEG_HI)));
	assign sec_hit = SECURE_PROT_EN && !EXEC_IN_SECURE &&
		((s_mem_eff && in_seg(s_ea, SEC_SEG_LO, SEC_SEG_HI)) ||
		 (d_mem_eff && in_seg(d_ea, SEC_SEG_LO, SEC_SEG_HI)));

	// program space mapping
	always_comb begin
		space_next = OAG_S_DATA;
		pa_next    = `OAG_PA_RST;
		fault_next = boot_hit || sec_hit;
		if (TABLE_ACCESS) begin
			space_next = OAG_S_TABLE;
			pa_next    = {TABLE_PAGE_VALUE, s_ea};
		end else if (PROGRAM_WINDOW_REMAP && s_mem_eff && s_ea[DW-1]) begin
			space_next = OAG_S_REMAP;
			pa_next    = {1'b0, VISIBILITY_PAGE_VALUE,
				s_ea[`OAG_VIS_LOW_W-1:0]};
			if (IS_WRITE)
				fault_next = 1'b1;
		end
	end

	// response registers
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			RSP_VALID <= 1'b0;
		end else begin
			RSP_VALID <= REQ_VALID;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			SRC_EA     <= `OAG_EA_RST;
			DST_EA     <= `OAG_EA_RST;
			SRC_IS_MEM <= 1'b0;
			DST_IS_MEM <= 1'b0;
		end else if (REQ_VALID) begin
			SRC_EA     <= s_ea;
			DST_EA     <= d_ea;
			SRC_IS_MEM <= s_mem_eff;
			DST_IS_MEM <= d_mem_eff;
		end
	end

	// pointer write-back
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			SRC_PTR_NEW <= `OAG_EA_RST;
			DST_PTR_NEW <= `OAG_EA_RST;
			SRC_PTR_WR  <= 1'b0;
			DST_PTR_WR  <= 1'b0;
		end else begin
			SRC_PTR_NEW <= s_pn;
			DST_PTR_NEW <= d_pn;
			SRC_PTR_WR  <= REQ_VALID && s_pw && !fault_next;
			DST_PTR_WR  <= REQ_VALID && d_pw && !fault_next;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			DST_TO_ACC     <= 1'b0;
			OFFSET_SEL_OUT <= '0;
		end else if (REQ_VALID) begin
			DST_TO_ACC     <= src_file && !DST_TO_FILE &&
				REQ_CLASS == OAG_C_GEN;
			OFFSET_SEL_OUT <= OFFSET_SEL;
		end
	end

	// program space outputs
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			SPACE         <= OAG_S_DATA;
			PROG_ADDR     <= `OAG_PA_RST;
			CONFIG_SPACE  <= 1'b0;
			TABLE_HI_BYTE <= 1'b0;
			ACCESS_FAULT  <= 1'b0;
		end else if (REQ_VALID) begin
			SPACE         <= space_next;
			PROG_ADDR     <= pa_next;
			CONFIG_SPACE  <= TABLE_ACCESS &&
				TABLE_PAGE_VALUE[`OAG_PAGE_W-1];
			TABLE_HI_BYTE <= TABLE_ACCESS && TABLE_BYTE_HI;
			ACCESS_FAULT  <= fault_next;
		end else begin
			ACCESS_FAULT  <= 1'b0;
		end
	end

	// assertions
	sequence s_req;
		REQ_VALID;
	endsequence

	property p_valid;
		@(posedge REF_CLK) disable iff (SYS_RST)
		s_req |=> RSP_VALID;
	endproperty
	a_valid: assert property (p_valid) else $error("response missing");
	property p_boot;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && boot_hit) |=> ACCESS_FAULT;
	endproperty
	a_boot: assert property (p_boot) else $error("boot fault lost");
	property p_sec;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && sec_hit) |=> ACCESS_FAULT;
	endproperty
	a_sec: assert property (p_sec) else $error("secure fault lost");
	property p_file;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && src_file) |=> SRC_EA < `OAG_NEAR_BYTES;
	endproperty
	a_file: assert property (p_file) else $error("file beyond near");
	property p_ind;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && src_m == OAG_M_IND) |=> SRC_EA == $past(SRC_PTR);
	endproperty
	a_ind: assert property (p_ind) else $error("indirect ea wrong");
	property p_post;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && src_m == OAG_M_POST) |=>
			SRC_EA == $past(SRC_PTR) &&
			SRC_PTR_NEW == 16'($past(SRC_PTR) +
			($past(STEP_DEC) ? -$past(STEP) : $past(STEP)));
	endproperty
	a_post: assert property (p_post) else $error("post ea wrong");
	property p_pre;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && src_m == OAG_M_PRE) |=>
			SRC_EA == SRC_PTR_NEW &&
			SRC_EA == 16'($past(SRC_PTR) +
			($past(STEP_DEC) ? -$past(STEP) : $past(STEP)));
	endproperty
	a_pre: assert property (p_pre) else $error("pre ea wrong");

	property p_idx;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && src_m == OAG_M_INDEX) |=>
			SRC_EA == 16'($past(SRC_PTR) + $past(OFFSET_SOURCE_REGISTER));
	endproperty
	a_idx: assert property (p_idx) else $error("index ea wrong");

	property p_three;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && REQ_CLASS == OAG_C_THREE &&
			SRC_MODE == OAG_M_INDEX) |=> !SRC_IS_MEM;
	endproperty
	a_three: assert property (p_three) else $error("bad three mode");

	property p_remap;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && space_next == OAG_S_REMAP) |=>
			PROG_ADDR[14:0] == SRC_EA[14:0] && !PROG_ADDR[PW-1];
	endproperty
	a_remap: assert property (p_remap) else $error("remap addr");

	property p_table;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(REQ_VALID && TABLE_ACCESS) |=>
			PROG_ADDR[DW-1:0] == SRC_EA &&
			CONFIG_SPACE == PROG_ADDR[PW-1];
	endproperty
	a_table: assert property (p_table) else $error("table addr");
endmodule // oag_top

// file: tb/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model
	import oag_pkg::*;
(
	// clock and response
	input  wire logic        clk,
	input  wire logic        rsp_valid,
	input  wire oag_space_t  space,
	// addresses
	input  wire logic [15:0] data_ea,
	input  wire logic [23:0] prog_addr,
	// read data
	output logic      [15:0] rdata
);
	initial rdata = 16'h0000;
	always @(posedge clk) begin
		if (rsp_valid && space == OAG_S_REMAP)
			rdata <= prog_addr[15:0] ^ 16'h0f0f;
		else if (rsp_valid)
			rdata <= data_ea ^ 16'h3c3c;
		else
			rdata <= ~rdata;
	end
endmodule // oag_mem_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import oag_pkg::*;
;
	logic clk, rst, req, sdec, tofile, wr, tbl, tblhi;
	logic ben, sen, inb, ins, remap;
	oag_class_t cls;
	oag_mode_t sm, dm;
	logic [15:0] sp, dp, ofs, lit, step, blo, bhi, slo, shi;
	logic [3:0] osel;
	logic [7:0] tpg, vpg;
	logic rv, smem, dmem, spw, dpw, acc, cfg, hib, flt;
	logic [15:0] sea, dea, spn, dpn, rdata;
	logic [3:0] oso;
	oag_space_t spc;
	logic [23:0] pa;
	int fails, checked;

	oag_top dut (.REF_CLK(clk), .SYS_RST(rst), .REQ_VALID(req),
		.REQ_CLASS(cls), .SRC_MODE(sm), .DST_MODE(dm), .SRC_PTR(sp),
		.DST_PTR(dp), .OFFSET_SOURCE_REGISTER(ofs), .OFFSET_SEL(osel),
		.OPCODE_LIT(lit), .STEP(step), .STEP_DEC(sdec),
		.DST_TO_FILE(tofile), .IS_WRITE(wr), .TABLE_ACCESS(tbl),
		.TABLE_BYTE_HI(tblhi), .BOOT_PROT_EN(ben), .SECURE_PROT_EN(sen),
		.EXEC_IN_BOOT(inb), .EXEC_IN_SECURE(ins), .BOOT_SEG_LO(blo),
		.BOOT_SEG_HI(bhi), .SEC_SEG_LO(slo), .SEC_SEG_HI(shi),
		.TABLE_PAGE_VALUE(tpg), .VISIBILITY_PAGE_VALUE(vpg),
		.PROGRAM_WINDOW_REMAP(remap), .RSP_VALID(rv), .SRC_EA(sea),
		.DST_EA(dea), .SRC_IS_MEM(smem), .DST_IS_MEM(dmem),
		.SRC_PTR_NEW(spn), .SRC_PTR_WR(spw), .DST_PTR_NEW(dpn),
		.DST_PTR_WR(dpw), .DST_TO_ACC(acc), .OFFSET_SEL_OUT(oso),
		.SPACE(spc), .PROG_ADDR(pa), .CONFIG_SPACE(cfg),
		.TABLE_HI_BYTE(hib), .ACCESS_FAULT(flt));

	oag_mem_model mem (.clk(clk), .rsp_valid(rv), .space(spc),
		.data_ea(sea), .prog_addr(pa), .rdata(rdata));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task test_done;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask

	task clr;
		{sdec, tofile, wr, tbl, tblhi, ben, sen, inb, ins} = '0;
		remap = 1'b0;
		cls = OAG_C_GEN;
		sm = OAG_M_REG;
		dm = OAG_M_REG;
		{sp, dp, ofs, lit, step, osel, tpg, vpg} = '0;
		blo = 16'h0800;
		bhi = 16'h08ff;
		slo = 16'h0900;
		shi = 16'h09ff;
	endtask

	// idle edge, one request, then wait for the answer at a falling edge
	task go;
		int n;
		@(negedge clk);
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		for (n = 0; n < 4 && rv !== 1'b1; n++)
			@(negedge clk);
		if (n == 4) begin
			fails++;
			test_done();
		end
	endtask

	task t_ind;
		clr();
		sm = OAG_M_IND;
		sp = 16'h1234;
		go();
		chk("ind ea", 24'h1234, sea);
		chk("ind wr", 24'h0, spw);
		chk("ind mem", 24'h1, smem);
	endtask

	task t_post;
		clr();
		sm = OAG_M_POST;
		sp = 16'hfffe;
		step = 16'h0002;
		go();
		chk("post ea", 24'hfffe, sea);
		chk("post new", 24'h0000, spn);
		chk("post wr", 24'h1, spw);
	endtask

	task t_pre;
		clr();
		sm = OAG_M_PRE;
		step = 16'h0002;
		sdec = 1'b1;
		go();
		chk("pre ea", 24'hfffe, sea);
		chk("pre new", 24'hfffe, spn);
	endtask

	task t_move;
		clr();
		cls = OAG_C_MOVE;
		sm = OAG_M_INDEX;
		sp = 16'hfff0;
		ofs = 16'h0020;
		osel = 4'ha;
		dm = OAG_M_LITOFS;
		dp = 16'hc000;
		lit = 16'h0004;
		go();
		chk("idx ea", 24'h0010, sea);
		chk("lofs ea", 24'hc004, dea);
		chk("dst mem", 24'h1, dmem);
		chk("osel", 24'ha, oso);
		chk("src mem", 24'h1, smem);
	endtask

	task t_file;
		clr();
		sm = OAG_M_FILE;
		lit = 16'hffff;
		go();
		chk("file ea", 24'h1fff, sea);
		chk("to acc", 24'h1, acc);
		clr();
		sm = OAG_M_FILE;
		tofile = 1'b1;
		go();
		chk("to file", 24'h0, acc);
	endtask

	task t_prot;
		for (int k = 0; k < 4; k++) begin
			clr();
			sm = OAG_M_IND;
			sp = k[1] ? 16'h0904 : 16'h0804;
			ben = 1'b1;
			sen = 1'b1;
			inb = k[0] & ~k[1];
			ins = k[0] & k[1];
			go();
			chk("fault", {23'h0, ~k[0]}, flt);
		end
	endtask

	task t_table;
		clr();
		tbl = 1'b1;
		sm = OAG_M_IND;
		sp = 16'h1234;
		tpg = 8'h85;
		tblhi = 1'b1;
		go();
		chk("tbl addr", 24'h851234, pa);
		chk("cfg", 24'h1, cfg);
		chk("tbl spc", OAG_S_TABLE, spc);
		chk("hi byte", 24'h1, hib);
	endtask

	task t_remap;
		clr();
		remap = 1'b1;
		sm = OAG_M_IND;
		sp = 16'h9234;
		vpg = 8'h3c;
		go();
		chk("rmp addr", 24'h1e1234, pa);
		chk("rmp spc", OAG_S_REMAP, spc);
		@(negedge clk);
		chk("rmp data", 24'h1d3b, rdata);
		clr();
		remap = 1'b1;
		sm = OAG_M_POST;
		sp = 16'h9234;
		wr = 1'b1;
		go();
		chk("rmp wr", 24'h1, flt);
		chk("rmp pwr", 24'h0, spw);
	endtask

	task t_reset;
		rst = 1'b1;
		@(negedge clk);
		@(negedge clk);
		chk("rst addr", 24'h0, pa);
		chk("rst ea", 24'h0, sea);
		chk("rst valid", 24'h0, rv);
		rst = 1'b0;
	endtask

	task t_lits;
		clr();
		cls = OAG_C_THREE;
		sm = OAG_M_INDEX;
		sp = 16'h0804;
		ben = 1'b1;
		go();
		chk("three mem", 24'h0, smem);
		chk("three flt", 24'h0, flt);
		clr();
		cls = OAG_C_THREE;
		sm = OAG_M_LIT5;
		dm = OAG_M_POST;
		dp = 16'h2000;
		step = 16'h0002;
		lit = 16'hffff;
		go();
		chk("lit5", 24'h001f, sea);
		chk("lit5 mem", 24'h0, smem);
		chk("three dst", 24'h2000, dea);
		chk("dst mem", 24'h1, dmem);
		chk("dst new", 24'h2002, dpn);
		chk("dst wr", 24'h1, dpw);
		clr();
		sm = OAG_M_LIT10;
		lit = 16'hffff;
		go();
		chk("lit10", 24'h03ff, sea);
		clr();
		cls = OAG_C_MOVE;
		sm = OAG_M_LIT8;
		dm = OAG_M_LIT16;
		lit = 16'hffff;
		go();
		chk("lit8", 24'h00ff, sea);
		chk("lit16", 24'hffff, dea);
		clr();
		cls = OAG_C_OTHER;
		sm = OAG_M_HOLD;
		lit = 16'hffff;
		go();
		chk("hold", 24'h3fff, sea);
		clr();
		cls = OAG_C_OTHER;
		sm = OAG_M_JUMP;
		lit = 16'h8001;
		go();
		chk("jump", 24'h8001, sea);
		chk("jump mem", 24'h0, smem);
	endtask

	initial begin
		fails = 0;
		checked = 0;
		req = 1'b0;
		clr();
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		t_ind();
		t_post();
		t_pre();
		t_move();
		t_file();
		t_prot();
		t_table();
		t_reset();
		t_remap();
		t_lits();
		test_done();
	end
endmodule // testbench
